// ==== verilog/e3tx_line_encoder.sv ====
// e3tx_line_encoder: transmit line interface stage, unipolar / ami / hdb3 rails.
// assumes the framer presents one bit per rising edge of i_tx_line_clock, and a
// register master on i_clk with one-cycle strobes and read data one cycle later.
`timescale 1ns/1ps

module e3tx_line_encoder (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  output logic            o_bipolar_code_select,
  output logic            o_rail_mode_unipolar,
  output logic            o_rx_clock_edge_select,
  output logic            o_tx_clock_loss_disable,
  output logic            o_rx_clock_loss_disable,
  output logic            o_reframe,
  input  wire logic       i_tx_line_clock,
  input  wire logic       i_tx_data,
  input  wire logic       i_tx_frame_start,
  output logic            o_tx_positive_rail,
  output logic            o_tx_negative_rail
);

  // ---------------- register side, i_clk domain ----------------
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       link_ready_sys;

  // write path; loss flag bit stays zero since loss detection lives elsewhere
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (i_wr_en && (i_addr == e3tx_pkg::ADDR_LINE_IF_CTRL)) begin
      ctrl_nxt = i_wr_data & e3tx_pkg::CTRL_WR_MASK;
    end
  end

  // read path; data valid only in the cycle after the strobe
  always_comb begin
    rd_data_nxt = e3tx_pkg::RD_UNMAPPED;
    if (i_rd_en) begin
      if (i_addr == e3tx_pkg::ADDR_LINE_IF_CTRL) begin
        rd_data_nxt = ctrl_r;
      end else if (i_addr == e3tx_pkg::ADDR_LINE_STATUS) begin
        rd_data_nxt = e3tx_pkg::RD_UNMAPPED;
        rd_data_nxt[e3tx_pkg::BIT_LINK_READY] = link_ready_sys;
      end else begin
        rd_data_nxt = e3tx_pkg::RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl_r    <= e3tx_pkg::CTRL_RESET;
      rd_data_r <= e3tx_pkg::RD_UNMAPPED;
    end else begin
      ctrl_r    <= ctrl_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign o_rd_data               = rd_data_r;
  assign o_bipolar_code_select   = ctrl_r[e3tx_pkg::BIT_CODE_SEL];
  assign o_rail_mode_unipolar    = ctrl_r[e3tx_pkg::BIT_UNIPOLAR];
  assign o_rx_clock_edge_select  = ctrl_r[e3tx_pkg::BIT_RX_EDGE_SEL];
  assign o_tx_clock_loss_disable = ctrl_r[e3tx_pkg::BIT_TX_LOSS_DIS];
  assign o_rx_clock_loss_disable = ctrl_r[e3tx_pkg::BIT_RX_LOSS_DIS];
  assign o_reframe               = ctrl_r[e3tx_pkg::BIT_REFRAME];

  // ---------------- crossings ----------------
  e3tx_pkg::e3tx_cfg_t cfg_sys;
  e3tx_pkg::e3tx_cfg_t cfg_lnk;
  logic [e3tx_pkg::CFG_W:0] to_lnk;
  logic [e3tx_pkg::CFG_W:0] at_lnk;
  logic                     lnk_nrst;
  logic                     lnk_ready_r;

  assign cfg_sys.code_ami  = ctrl_r[e3tx_pkg::BIT_CODE_SEL];
  assign cfg_sys.unipolar  = ctrl_r[e3tx_pkg::BIT_UNIPOLAR];
  assign cfg_sys.edge_fall = ctrl_r[e3tx_pkg::BIT_TX_EDGE_SEL];
  assign to_lnk            = {i_nrst, cfg_sys};

  // settings are independent levels, so per-bit sync is safe
  e3tx_sync #(.W(e3tx_pkg::CFG_W + 1)) u_sync_to_lnk (
    .i_clk (i_tx_line_clock),
    .i_d   (to_lnk),
    .o_q   (at_lnk)
  );

  assign lnk_nrst = at_lnk[e3tx_pkg::CFG_W];
  assign cfg_lnk  = at_lnk[e3tx_pkg::CFG_W-1:0];

  // link reset release reported back as status
  e3tx_sync #(.W(1)) u_sync_to_sys (
    .i_clk (i_clk),
    .i_d   (lnk_ready_r),
    .o_q   (link_ready_sys)
  );

  // ---------------- encoder, line clock domain ----------------
  e3tx_pkg::e3tx_slot_t  pipe_r   [e3tx_pkg::PIPE_DEPTH];
  e3tx_pkg::e3tx_slot_t  pipe_nxt [e3tx_pkg::PIPE_DEPTH];
  e3tx_pkg::e3tx_slot_t  in_slot;
  e3tx_pkg::e3tx_rails_t rise_r;
  e3tx_pkg::e3tx_rails_t rise_nxt;
  e3tx_pkg::e3tx_rails_t fall_r;
  logic                  b_odd_r;
  logic                  b_odd_nxt;
  logic                  last_neg_r;
  logic                  last_neg_nxt;
  logic                  hdb3_on;
  logic                  zero_run;
  logic                  out_neg;

  assign hdb3_on = !cfg_lnk.code_ami && !cfg_lnk.unipolar;

  // lookahead shift and zero-run substitution; b parity is counted at the
  // input because slots already in the pipe are zeros when a run is found
  always_comb begin
    in_slot.pulse = i_tx_data;
    in_slot.viol  = 1'b0;
    in_slot.frame = i_tx_frame_start;
    b_odd_nxt     = b_odd_r;
    zero_run      = !i_tx_data && !pipe_r[0].pulse && !pipe_r[1].pulse && !pipe_r[2].pulse;
    for (int i = e3tx_pkg::PIPE_DEPTH - 1; i > 0; i--) begin
      pipe_nxt[i] = pipe_r[i-1];
    end
    pipe_nxt[0] = in_slot;
    if (hdb3_on && zero_run) begin
      pipe_nxt[0].pulse = 1'b1;
      pipe_nxt[0].viol  = 1'b1;
      if (!b_odd_r) begin
        pipe_nxt[e3tx_pkg::PIPE_DEPTH-1].pulse = 1'b1;   // B00V
      end
      b_odd_nxt = 1'b0;
    end else if (i_tx_data && !cfg_lnk.unipolar) begin
      b_odd_nxt = !b_odd_r;
    end
  end

  // polarity choice at the pipe exit; zeros never touch last_neg_r
  always_comb begin
    out_neg      = pipe_r[e3tx_pkg::PIPE_DEPTH-1].viol ? last_neg_r : !last_neg_r;
    last_neg_nxt = last_neg_r;
    rise_nxt     = '0;
    if (cfg_lnk.unipolar) begin
      rise_nxt.pos = pipe_r[e3tx_pkg::PIPE_DEPTH-1].pulse;
      rise_nxt.neg = pipe_r[e3tx_pkg::PIPE_DEPTH-1].frame;
    end else if (pipe_r[e3tx_pkg::PIPE_DEPTH-1].pulse) begin
      rise_nxt.pos = !out_neg;
      rise_nxt.neg = out_neg;
      last_neg_nxt = out_neg;
    end
  end

  // last polarity starts negative so the first mark goes out positive
  always_ff @(posedge i_tx_line_clock) begin
    if (!lnk_nrst) begin
      for (int i = 0; i < e3tx_pkg::PIPE_DEPTH; i++) begin
        pipe_r[i] <= '0;
      end
      rise_r      <= '0;
      b_odd_r     <= 1'b0;
      last_neg_r  <= 1'b1;
      lnk_ready_r <= 1'b0;
    end else begin
      pipe_r      <= pipe_nxt;
      rise_r      <= rise_nxt;
      b_odd_r     <= b_odd_nxt;
      last_neg_r  <= last_neg_nxt;
      lnk_ready_r <= 1'b1;
    end
  end

  // half-cycle retimed copy for falling-edge launch
  always_ff @(negedge i_tx_line_clock) begin
    if (!lnk_nrst) begin
      fall_r <= '0;
    end else begin
      fall_r <= rise_r;
    end
  end

  // the select is a synchronised level, so the pick only moves with the line clock
  assign o_tx_positive_rail = cfg_lnk.edge_fall ? fall_r.pos : rise_r.pos;
  assign o_tx_negative_rail = cfg_lnk.edge_fall ? fall_r.neg : rise_r.neg;

  // ---------------- checks ----------------
  logic [2:0] quiet_cnt_r;
  logic       bsince_odd_r;
  logic       seen_v_r;
  logic       first_pend_r;
  e3tx_pkg::e3tx_slot_t exit_slot;

  assign exit_slot = pipe_r[e3tx_pkg::PIPE_DEPTH-1];

  // no pulse has left the pipe since reset; the reset flush zeros are not coded data
  always_ff @(posedge i_tx_line_clock) begin
    if (!lnk_nrst) begin
      first_pend_r <= 1'b1;
    end else if (exit_slot.pulse) begin
      first_pend_r <= 1'b0;
    end
  end

  // zero-slot run length and b parity as seen at the pipe exit
  always_ff @(posedge i_tx_line_clock) begin
    if (!lnk_nrst || !hdb3_on || first_pend_r) begin
      quiet_cnt_r  <= 3'h0;
      bsince_odd_r <= 1'b0;
      seen_v_r     <= 1'b0;
    end else begin
      quiet_cnt_r  <= exit_slot.pulse ? 3'h0 : ((quiet_cnt_r == 3'h7) ? 3'h7 : quiet_cnt_r + 3'h1);
      if (exit_slot.pulse && exit_slot.viol) begin
        bsince_odd_r <= 1'b0;
        seen_v_r     <= 1'b1;
      end else if (exit_slot.pulse) begin
        bsince_odd_r <= !bsince_odd_r;
      end
    end
  end

  rails_excl_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    !cfg_lnk.unipolar |-> !(rise_r.pos && rise_r.neg))
    else $error("both rails high in bipolar mode");

  mark_alt_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    (!cfg_lnk.unipolar && exit_slot.pulse && !exit_slot.viol) |=> (rise_r.neg == !$past(last_neg_r)))
    else $error("mark did not alternate polarity");

  viol_same_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    (!cfg_lnk.unipolar && exit_slot.pulse && exit_slot.viol) |=> (rise_r.neg == $past(last_neg_r)))
    else $error("violation pulse did not repeat polarity");

  space_quiet_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    (!cfg_lnk.unipolar && !exit_slot.pulse) |=> (!rise_r.pos && !rise_r.neg))
    else $error("zero slot drove a rail");

  zero_hold_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    (!cfg_lnk.unipolar && !exit_slot.pulse) |=> (last_neg_r == $past(last_neg_r)))
    else $error("zero changed expected polarity");

  hdb3_run_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    hdb3_on |-> (quiet_cnt_r < 3'h4))
    else $error("four empty slots sent in hdb3");

  odd_b_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    (hdb3_on && seen_v_r && exit_slot.pulse && exit_slot.viol) |-> bsince_odd_r)
    else $error("even b count between violations");

  ami_no_v_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    (cfg_lnk.code_ami && $stable(cfg_lnk.code_ami)) |=> !pipe_r[0].viol)
    else $error("substitution inserted in ami");

  uni_rail_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    cfg_lnk.unipolar |=> (rise_r.pos == $past(exit_slot.pulse) && rise_r.neg == $past(exit_slot.frame)))
    else $error("unipolar rails wrong");

  ctrl_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_wr_en && i_addr == e3tx_pkg::ADDR_LINE_IF_CTRL)
      |=> (ctrl_r[e3tx_pkg::BIT_CODE_SEL] == $past(i_wr_data[e3tx_pkg::BIT_CODE_SEL])))
    else $error("code select write not taken");

  first_mark_a: assert property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    (first_pend_r && !cfg_lnk.unipolar && exit_slot.pulse) |=> rise_r.pos)
    else $error("first mark not positive");

  cov_b00v_c:  cover property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    hdb3_on && zero_run && !b_odd_r);
  cov_000v_c:  cover property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    hdb3_on && zero_run && b_odd_r);
  cov_fall_c:  cover property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    cfg_lnk.edge_fall && rise_r.neg);
  cov_uni_c:   cover property (@(posedge i_tx_line_clock) disable iff (!lnk_nrst)
    cfg_lnk.unipolar && rise_r.neg);

endmodule

// ==== verilog/e3tx_pkg.sv ====
// e3tx_pkg: shared constants and types for the e3 transmit line encoder.
// assumes an 8-bit register port and a one-bit-per-clock outbound framer stream.
package e3tx_pkg;

  // register map
  localparam logic [7:0] ADDR_LINE_IF_CTRL = 8'h01;
  localparam logic [7:0] ADDR_LINE_STATUS  = 8'h02;

  // line_interface_control field positions
  localparam int BIT_TX_LOSS_DIS  = 7;
  localparam int BIT_LOSS_FLAG    = 6;
  localparam int BIT_RX_LOSS_DIS  = 5;
  localparam int BIT_CODE_SEL     = 4;
  localparam int BIT_UNIPOLAR     = 3;
  localparam int BIT_TX_EDGE_SEL  = 2;
  localparam int BIT_RX_EDGE_SEL  = 1;
  localparam int BIT_REFRAME      = 0;

  // line_status field positions
  localparam int BIT_LINK_READY   = 0;

  // reset values and writable mask (loss flag is read-only)
  localparam logic [7:0] CTRL_RESET    = 8'ha0;
  localparam logic [7:0] CTRL_WR_MASK  = 8'hbf;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // hdb3 lookahead depth: one substitution spans four bit slots
  localparam int HDB3_RUN          = 4;
  localparam int PIPE_DEPTH        = HDB3_RUN;

  // settings carried into the line clock domain
  typedef struct packed {
    logic code_ami;   // 1 = ami, 0 = hdb3
    logic unipolar;   // 1 = single rail
    logic edge_fall;  // 1 = rails change on falling edge
  } e3tx_cfg_t;

  localparam int CFG_W = $bits(e3tx_cfg_t);

  // one bit slot in the encoder lookahead
  typedef struct packed {
    logic pulse;      // mark, b or v pulse in this slot
    logic viol;       // pulse is a bipolar violation
    logic frame;      // slot is the first bit of a frame
  } e3tx_slot_t;

  // rail pair towards the line interface unit
  typedef struct packed {
    logic pos;
    logic neg;
  } e3tx_rails_t;

endpackage

// ==== verilog/e3tx_sync.sv ====
// e3tx_sync: two-flop synchroniser for a bus of independent levels.
// assumes each bit may change alone; not for multi-bit words that must stay coherent.
`timescale 1ns/1ps

module e3tx_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    meta_r <= i_d;
    q_r    <= meta_r;
  end

  assign o_q = q_r;

endmodule

// ==== dv/e3tx_liu_model.sv ====
// e3tx_liu_model: behavioural line interface unit on the far side of the rails.
// assumes the bench tells it which line clock edge updates the rails.
`timescale 1ns/1ps

module e3tx_liu_model (
  input  wire e3tx_pkg::e3tx_rails_t i_rails,
  input  wire logic                  i_edge_fall,
  output logic                       o_line_clk
);
  e3tx_pkg::e3tx_rails_t syms[$];
  e3tx_pkg::e3tx_rails_t at_pos;
  e3tx_pkg::e3tx_rails_t at_neg;
  int                    edge_err = 0;
  int                    both_err = 0;

  // free running line clock, phase unrelated to the register clock
  initial begin
    o_line_clk = 1'b0;
    #7;
    forever #16 o_line_clk = ~o_line_clk;
  end

  // rising edge: old value must match last fall sample when rails move on rise
  always @(posedge o_line_clk) begin
    if (!i_edge_fall && i_rails !== at_neg) edge_err++;
    if (i_edge_fall) syms.push_back(i_rails);
    at_pos = i_rails;
  end

  // falling edge: sample mid-bit in rising mode, the way a real unit would
  always @(negedge o_line_clk) begin
    if (i_edge_fall && i_rails !== at_pos) edge_err++;
    if (!i_edge_fall) syms.push_back(i_rails);
    if (i_rails.pos && i_rails.neg) both_err++;
    at_neg = i_rails;
  end
endmodule

// ==== dv/e3tx_line_encoder_tb.sv ====
// e3tx_line_encoder_tb: self-checking bench for the transmit line encoder.
// assumes the liu model makes the line clock and logs one rail pair per bit.
`timescale 1ns/1ps

module e3tx_line_encoder_tb;
  logic                  i_clk     = 1'b0;
  logic                  i_nrst    = 1'b0;
  logic                  wr_en     = 1'b0;
  logic                  rd_en     = 1'b0;
  logic                  tx_data   = 1'b1;
  logic                  frame     = 1'b0;
  logic                  edge_fall = 1'b0;
  logic [7:0]            addr      = 8'h00;
  logic [7:0]            wdata     = 8'h00;
  wire  [7:0]            rd_data;
  wire                   code_sel;
  wire                   unip;
  wire                   pos_w;
  wire                   neg_w;
  wire                   line_clk;
  wire  [3:0]            side;
  e3tx_pkg::e3tx_rails_t rails;
  int                    bad_count = 0;
  int                    tests_run = 0;
  int                    cycles    = 0;

  assign rails = {pos_w, neg_w};

  // register clock, and a ceiling far above the couple of hundred cycles needed
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      results();
    end
  end

  e3tx_line_encoder i_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .o_rd_data(rd_data), .o_bipolar_code_select(code_sel),
    .o_rail_mode_unipolar(unip), .o_rx_clock_edge_select(side[1]), .o_tx_clock_loss_disable(side[3]),
    .o_rx_clock_loss_disable(side[2]), .o_reframe(side[0]), .i_tx_line_clock(line_clk), .i_tx_data(tx_data),
    .i_tx_frame_start(frame), .o_tx_positive_rail(pos_w), .o_tx_negative_rail(neg_w)
  );

  e3tx_liu_model i_liu (.i_rails(rails), .i_edge_fall(edge_fall), .o_line_clk(line_clk));

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge i_clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge i_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // line clock keeps running, so 5 register cycles also cover the line domain
  task do_reset;
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_liu.syms.delete();
    i_nrst <= 1'b1;
  endtask

  task regs;
    logic [7:0] d;
    do_reset();
    rd(8'h01, d);
    check("ctrl reset", d, 8'ha0);
    check("unipolar out", {7'h0, unip}, 8'h00);
    check("side outs reset", {4'h0, side}, 8'h0c);
    wr(8'h01, 8'hff);
    rd(8'h01, d);
    check("ctrl loss bit", d, 8'hbf);
    check("code out ami", {7'h0, code_sel}, 8'h01);
    check("side outs set", {4'h0, side}, 8'h0f);
    wr(8'h01, 8'h00);
    check("code out hdb3", {7'h0, code_sel}, 8'h00);
    check("side outs clear", {4'h0, side}, 8'h00);
    wr(8'h07, 8'h5a);
    rd(8'h01, d);
    check("stray write", d, 8'h00);
    rd(8'h07, d);
    check("unmapped read", d, 8'h00);
    rd(8'h02, d);
    check("link status", d, 8'h01);
    $display("test regs done");
  endtask

  function automatic logic [1:0] rl(input int p);
    return (p > 0) ? 2'b10 : 2'b01;
  endfunction

  // prefix of ones codes the same in ami and hdb3, so config can settle under it
  task automatic stream(input string nm, input logic [7:0] cfg, input logic [31:0] pat, input logic [31:0] fr);
    logic [1:0]  e[$];
    logic [39:0] bits;
    int          k;
    int          i;
    int          lp;
    int          e0;
    int          b0;
    logic        par;
    do_reset();
    wr(8'h01, cfg);
    edge_fall = cfg[2];
    repeat (20) @(posedge line_clk);
    e0 = i_liu.edge_err;
    b0 = i_liu.both_err;
    for (i = 0; i < 24; i++) begin
      @(posedge line_clk);
      tx_data <= pat[i];
      frame <= fr[i];
    end
    @(posedge line_clk);
    tx_data <= 1'b1;
    frame <= 1'b0;
    repeat (16) @(posedge line_clk);
    k = 0;
    while (k < 200 && i_liu.syms[k] == 2'b00) k++;
    check({nm, " first mark"}, {6'h0, i_liu.syms[k]}, 8'h02);
    while (k < 200 && i_liu.syms[k] != 2'b00) k++;
    lp = i_liu.syms[k-1].pos ? 1 : -1;
    par = (lp == 1);
    bits = {8'hff, pat};
    i = 0;
    // reference coder: par is odd count of b pulses since the last violation
    while (i < 24) begin
      if (cfg[3]) begin
        e.push_back({bits[i], fr[i]});
        i++;
      end else if (!cfg[4] && bits[i+:4] == 4'h0) begin
        if (!par) begin
          lp = -lp;
          e.push_back(rl(lp));
        end else e.push_back(2'b00);
        e.push_back(2'b00);
        e.push_back(2'b00);
        e.push_back(rl(lp));
        par = 1'b0;
        i += 4;
      end else begin
        if (bits[i]) begin
          lp = -lp;
          par = !par;
        end
        e.push_back(bits[i] ? rl(lp) : 2'b00);
        i++;
      end
    end
    for (i = 0; i < 24; i++) check({nm, " slot"}, {6'h0, i_liu.syms[k+i]}, {6'h0, e[i]});
    check({nm, " edge"}, 8'(i_liu.edge_err - e0), 8'h00);
    if (!cfg[3]) check({nm, " both rails"}, 8'(i_liu.both_err - b0), 8'h00);
    $display("test %s done", nm);
  endtask

  task ami_rise;
    stream("ami", 8'hb0, 32'hff818102, 32'h0);
  endtask

  task hdb3_fall;
    stream("hdb3", 8'ha4, 32'hff801002, 32'h0);
  endtask

  task unipolar;
    stream("unipolar", 8'ha8, 32'hfff0f002, 32'h00000100);
  endtask

  task results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    regs();
    ami_rise();
    hdb3_fall();
    unipolar();
    results();
  end
endmodule
